// file: inc/pvh_consts.vh
// constants shared by the peak value hold logic
`ifndef PVH_CONSTS_VH
`define PVH_CONSTS_VH

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define PVH_CLK_NS 25
`define PVH_SEC_NS 1000000000
`define PVH_SEC_CYCLES (`PVH_SEC_NS / `PVH_CLK_NS)

// ------------------------------------------------------------
// peak modes
// ------------------------------------------------------------
`define PVH_MODE_NORMAL 2'h0
`define PVH_MODE_PEAK 2'h1
`define PVH_MODE_SINGLE 2'h2
`define PVH_MODE_DOUBLE 2'h3

// ------------------------------------------------------------
// setting ranges and reset values
// ------------------------------------------------------------
`define PVH_LEVEL_MIN (-16'sd999)
`define PVH_LEVEL_MAX 16'sd9999
`define PVH_LEVEL_RST 16'h0064
`define PVH_CNT_MAX 7'h63
`define PVH_QDELAY_RST 7'h05
`define PVH_MWIN_RST 7'h05
`define PVH_FCYC_RST 7'h00
`define PVH_MODE_RST 2'h0

// ------------------------------------------------------------
// register map (byte addresses)
// ------------------------------------------------------------
`define PVH_REG_CTRL 8'h00
`define PVH_REG_LEVEL 8'h04
`define PVH_REG_QDELAY 8'h08
`define PVH_REG_MWIN 8'h0C
`define PVH_REG_FCYC 8'h10
`define PVH_REG_STATUS 8'h14
`define PVH_REG_DISP 8'h18
`define PVH_REG_FILT 8'h1C
`define PVH_CTRL_EXIT_BIT 8

// ------------------------------------------------------------
// bus responses
// ------------------------------------------------------------
`define PVH_RESP_OKAY 2'h0
`define PVH_RESP_SLVERR 2'h2

// ------------------------------------------------------------
// filter fixed point
// ------------------------------------------------------------
`define PVH_FRAC 8
`define PVH_HALF_LSB 8'h80

`endif

// file: rtl/pvh_sec_timer.v
// seconds countdown timer with restart and stop
`timescale 1ns/1ps
`include "pvh_consts.vh"

module pvh_sec_timer #(
	parameter TICK_CYCLES = `PVH_SEC_CYCLES,
	parameter CW = 26,
	parameter SW = 7
) (
	input wire aclk,
	input wire aresetn,
	input wire start,
	input wire stop,
	input wire [SW-1:0] secs,
	output reg expired
);

	reg [CW-1:0] pres_q;
	reg [SW-1:0] left_q;
	reg run_q;
	reg zero_q;

	always @(posedge aclk) begin
		if (!aresetn) begin
			pres_q <= {CW{1'b0}};
			left_q <= {SW{1'b0}};
			run_q <= 1'b0;
			zero_q <= 1'b0;
			expired <= 1'b0;
		end else begin
			expired <= 1'b0;
			zero_q <= 1'b0;
			if (stop) begin
				run_q <= 1'b0;
			end else if (start) begin
				pres_q <= {CW{1'b0}};
				left_q <= secs;
				run_q <= (secs != {SW{1'b0}});
				zero_q <= (secs == {SW{1'b0}});
			end else if (zero_q) begin
				// zero seconds: expire right away
				expired <= 1'b1;
			end else if (run_q) begin
				if (pres_q == TICK_CYCLES[CW-1:0] - {{(CW-1){1'b0}}, 1'b1}) begin
					pres_q <= {CW{1'b0}};
					left_q <= left_q - {{(SW-1){1'b0}}, 1'b1};
					if (left_q == {{(SW-1){1'b0}}, 1'b1}) begin
						run_q <= 1'b0;
						expired <= 1'b1;
					end
				end else begin
					pres_q <= pres_q + {{(CW-1){1'b0}}, 1'b1};
				end
			end
		end
	end

endmodule // pvh_sec_timer

// file: rtl/pvh_avg_filter.v
// single pole averaging filter, serial divider
`timescale 1ns/1ps
`include "pvh_consts.vh"

module pvh_avg_filter #(
	parameter W = 16,
	parameter NW = 7
) (
	input wire aclk,
	input wire aresetn,
	input wire in_valid,
	input wire signed [W-1:0] in_data,
	input wire [NW-1:0] ncyc,
	output reg out_valid,
	output reg signed [W-1:0] out_data
);

	localparam AW = W + `PVH_FRAC + 1;
	localparam DW = AW + 1;

	reg signed [AW-1:0] acc_q;
	reg [DW-1:0] mag_q;
	reg [DW-1:0] rem_q;
	reg [NW-1:0] div_q;
	reg [5:0] cnt_q;
	reg neg_q;
	reg busy_q;

	wire signed [AW-1:0] x_fx = {in_data[W-1], in_data, {`PVH_FRAC{1'b0}}};
	wire signed [DW-1:0] diff = {x_fx[AW-1], x_fx} - {acc_q[AW-1], acc_q};
	wire [DW-1:0] rem_sh = {rem_q[DW-2:0], mag_q[DW-1]};
	wire fit = (rem_sh >= {{(DW-NW){1'b0}}, div_q});
	wire [DW-1:0] quo = {mag_q[DW-2:0], fit};
	wire signed [AW-1:0] step = neg_q ? -quo[AW-1:0] : quo[AW-1:0];
	wire signed [AW-1:0] acc_nxt = acc_q + step;
	wire signed [AW-1:0] rnd_byp = x_fx + {{(AW-8){1'b0}}, `PVH_HALF_LSB};
	wire signed [AW-1:0] rnd_nxt = acc_nxt + {{(AW-8){1'b0}}, `PVH_HALF_LSB};

	always @(posedge aclk) begin
		if (!aresetn) begin
			acc_q <= {AW{1'b0}};
			mag_q <= {DW{1'b0}};
			rem_q <= {DW{1'b0}};
			div_q <= {NW{1'b0}};
			cnt_q <= 6'h00;
			neg_q <= 1'b0;
			busy_q <= 1'b0;
			out_valid <= 1'b0;
			out_data <= {W{1'b0}};
		end else begin
			out_valid <= 1'b0;
			if (!busy_q && in_valid) begin
				if (ncyc <= {{(NW-1){1'b0}}, 1'b1}) begin
					// bypass: output follows input
					acc_q <= x_fx;
					out_data <= rnd_byp[AW-2:`PVH_FRAC];
					out_valid <= 1'b1;
				end else begin
					// y += (x - y) / n
					neg_q <= diff[DW-1];
					mag_q <= diff[DW-1] ? -diff : diff;
					rem_q <= {DW{1'b0}};
					div_q <= ncyc;
					cnt_q <= DW[5:0];
					busy_q <= 1'b1;
				end
			end else if (busy_q) begin
				rem_q <= fit ? rem_sh - {{(DW-NW){1'b0}}, div_q} : rem_sh;
				mag_q <= quo;
				cnt_q <= cnt_q - 6'h01;
				if (cnt_q == 6'h01) begin
					busy_q <= 1'b0;
					acc_q <= acc_nxt;
					out_data <= rnd_nxt[AW-2:`PVH_FRAC];
					out_valid <= 1'b1;
				end
			end
		end
	end

endmodule // pvh_avg_filter

// file: rtl/pvh_peak_hold.v
// peak value hold, filtering and display test with AXI4-Lite settings
//
// The implementer's own choices: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "pvh_consts.vh"

// Overview of operation
// [R1] two-bit mode: normal, peak, single, double
// [R2] signed threshold -999..+9999, default 100
// [R3] qualification delay 0..99, default 5
// [R4] single-mode retention window 0..99, default 5
// [R5] averaging filter, constant cycles over rate
// [R6] step reaches 99.3 percent in five constants
// [R7] peak mode shows largest reading so far
// [R8] reset input or menu exit clears peak
// [R9] single mode below threshold shows live
// [R10] single: above threshold plus delay captures peak
// [R11] single: window expiry discards held peak
// [R12] single: higher reading recaptures, restarts window
// [R13] single: expiry while above restarts with reading
// [R14] double: qualified capture held without limit
// [R15] double: higher reading replaces held peak
// [R16] double: drop and rise starts fresh capture
// [R17] display test lights every segment
// [R18] zero filter cycles bypasses; else averaging count
// [R19] delays in seconds; drop restarts delay
// [R20] signed filtered compare; normal shows live
module pvh_peak_hold #(
	parameter W = 16,
	parameter SEC_CYCLES = `PVH_SEC_CYCLES
) (
	input wire aclk,
	input wire aresetn,
	input wire reading_valid,
	input wire signed [W-1:0] reading,
	input wire din_reset,
	input wire din_test,
	output reg signed [W-1:0] disp_value,
	output reg disp_valid,
	output reg disp_all_on,
	output reg disp_held,
	input wire [7:0] s_axi_awaddr,
	input wire [2:0] s_axi_awprot,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [7:0] s_axi_araddr,
	input wire [2:0] s_axi_arprot,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready
);

	localparam ST_LIVE = 2'd0;
	localparam ST_QUAL = 2'd1;
	localparam ST_HOLD = 2'd2;
	localparam ST_REARM = 2'd3;

	// ------------------------------------------------------------
	// functions
	// ------------------------------------------------------------
	function [6:0] clamp99;
		input [7:0] v;
		begin
			clamp99 = (v > {1'b0, `PVH_CNT_MAX}) ? `PVH_CNT_MAX : v[6:0];
		end
	endfunction

	function signed [15:0] clamp_level;
		input signed [15:0] v;
		begin
			if (v < `PVH_LEVEL_MIN) begin
				clamp_level = `PVH_LEVEL_MIN;
			end else if (v > `PVH_LEVEL_MAX) begin
				clamp_level = `PVH_LEVEL_MAX;
			end else begin
				clamp_level = v;
			end
		end
	endfunction

	// ------------------------------------------------------------
	// settings
	// ------------------------------------------------------------
	reg [1:0] mode_q;
	reg signed [15:0] level_q;
	reg [6:0] qdelay_q;
	reg [6:0] mwin_q;
	reg [6:0] fcyc_q;
	reg menu_exit_q;
	reg mode_wr_q;

	// ------------------------------------------------------------
	// bus slave state
	// ------------------------------------------------------------
	reg aw_have_q;
	reg w_have_q;
	reg [7:0] awaddr_q;
	reg [31:0] wdata_q;
	reg [3:0] wstrb_q;

	wire aw_take = s_axi_awvalid && s_axi_awready;
	wire w_take = s_axi_wvalid && s_axi_wready;
	wire wr_go = aw_have_q && w_have_q && !s_axi_bvalid;
	wire ar_take = s_axi_arvalid && s_axi_arready;

	// ------------------------------------------------------------
	// filter and timers
	// ------------------------------------------------------------
	wire fv;
	wire signed [W-1:0] filt;
	wire dly_done;
	wire mem_done;
	reg dly_go_q;
	reg dly_stop_q;
	reg mem_go_q;
	reg mem_stop_q;

	pvh_avg_filter #(
		.W(W),
		.NW(7)
	) u_filter (
		.aclk(aclk),
		.aresetn(aresetn),
		.in_valid(reading_valid),
		.in_data(reading),
		.ncyc(fcyc_q), // [R5] [R6] [R18]
		.out_valid(fv),
		.out_data(filt)
	);

	pvh_sec_timer #(
		.TICK_CYCLES(SEC_CYCLES),
		.CW(32),
		.SW(7)
	) u_delay (
		.aclk(aclk),
		.aresetn(aresetn),
		.start(dly_go_q),
		.stop(dly_stop_q),
		.secs(qdelay_q), // [R19]
		.expired(dly_done)
	);

	pvh_sec_timer #(
		.TICK_CYCLES(SEC_CYCLES),
		.CW(32),
		.SW(7)
	) u_window (
		.aclk(aclk),
		.aresetn(aresetn),
		.start(mem_go_q),
		.stop(mem_stop_q),
		.secs(mwin_q), // [R19]
		.expired(mem_done)
	);

	// ------------------------------------------------------------
	// register writes
	// ------------------------------------------------------------
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `PVH_RESP_OKAY;
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			awaddr_q <= 8'h00;
			wdata_q <= 32'h00000000;
			wstrb_q <= 4'h0;
			mode_q <= `PVH_MODE_RST; // [R1]
			level_q <= `PVH_LEVEL_RST; // [R2]
			qdelay_q <= `PVH_QDELAY_RST; // [R3]
			mwin_q <= `PVH_MWIN_RST; // [R4]
			fcyc_q <= `PVH_FCYC_RST;
			menu_exit_q <= 1'b0;
			mode_wr_q <= 1'b0;
		end else begin
			menu_exit_q <= 1'b0;
			mode_wr_q <= 1'b0;
			s_axi_awready <= !aw_have_q && !aw_take;
			s_axi_wready <= !w_have_q && !w_take;
			if (aw_take) begin
				aw_have_q <= 1'b1;
				awaddr_q <= s_axi_awaddr;
			end
			if (w_take) begin
				w_have_q <= 1'b1;
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
			if (wr_go) begin
				aw_have_q <= 1'b0;
				w_have_q <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= `PVH_RESP_OKAY;
				if (awaddr_q == `PVH_REG_CTRL) begin
					if (wstrb_q[0]) begin
						mode_q <= wdata_q[1:0]; // [R1]
						mode_wr_q <= 1'b1;
					end
					if (wstrb_q[1]) begin
						menu_exit_q <= wdata_q[`PVH_CTRL_EXIT_BIT];
					end
				end else if (awaddr_q == `PVH_REG_LEVEL) begin
					if (wstrb_q[1:0] == 2'h3) begin
						level_q <= clamp_level(wdata_q[15:0]); // [R2]
					end
				end else if (awaddr_q == `PVH_REG_QDELAY) begin
					if (wstrb_q[0]) begin
						qdelay_q <= clamp99(wdata_q[7:0]); // [R3]
					end
				end else if (awaddr_q == `PVH_REG_MWIN) begin
					if (wstrb_q[0]) begin
						mwin_q <= clamp99(wdata_q[7:0]); // [R4]
					end
				end else if (awaddr_q == `PVH_REG_FCYC) begin
					if (wstrb_q[0]) begin
						fcyc_q <= clamp99(wdata_q[7:0]); // [R18]
					end
				end else if (awaddr_q == `PVH_REG_STATUS || awaddr_q == `PVH_REG_DISP ||
					awaddr_q == `PVH_REG_FILT) begin
					s_axi_bresp <= `PVH_RESP_OKAY;
				end else begin
					s_axi_bresp <= `PVH_RESP_SLVERR;
				end
			end
		end
	end

	// ------------------------------------------------------------
	// peak state machine
	// ------------------------------------------------------------
	reg [1:0] st_q;
	reg held_q;
	reg signed [W-1:0] peak_q;
	reg signed [W-1:0] cand_q;
	reg signed [W-1:0] last_q;

	wire clr = din_reset || menu_exit_q || mode_wr_q;
	wire f_above = (filt > level_q); // [R20]
	wire signed [W-1:0] cmax = (fv && filt > cand_q) ? filt : cand_q;
	wire single = (mode_q == `PVH_MODE_SINGLE);

	always @(posedge aclk) begin
		if (!aresetn) begin
			st_q <= ST_LIVE;
			held_q <= 1'b0;
			peak_q <= {W{1'b0}};
			cand_q <= {W{1'b0}};
			last_q <= {W{1'b0}};
			dly_go_q <= 1'b0;
			dly_stop_q <= 1'b0;
			mem_go_q <= 1'b0;
			mem_stop_q <= 1'b0;
		end else begin
			dly_go_q <= 1'b0;
			dly_stop_q <= 1'b0;
			mem_go_q <= 1'b0;
			mem_stop_q <= 1'b0;
			if (fv) begin
				last_q <= filt;
			end
			if (clr) begin
				st_q <= ST_LIVE; // [R8]
				held_q <= 1'b0;
				dly_stop_q <= 1'b1;
				mem_stop_q <= 1'b1;
			end else if (mode_q == `PVH_MODE_NORMAL) begin
				st_q <= ST_LIVE; // [R20]
				held_q <= 1'b0;
			end else if (mode_q == `PVH_MODE_PEAK) begin
				if (fv && (!held_q || filt > peak_q)) begin
					peak_q <= filt; // [R7]
					held_q <= 1'b1;
				end
			end else begin
				case (st_q)
				ST_LIVE: begin
					if (fv && f_above) begin
						st_q <= ST_QUAL; // [R9]
						cand_q <= filt;
						dly_go_q <= 1'b1;
					end
				end
				ST_QUAL: begin
					cand_q <= cmax;
					if (fv && !f_above) begin
						st_q <= held_q ? ST_REARM : ST_LIVE; // [R19]
						dly_stop_q <= 1'b1;
					end else if (dly_done) begin
						st_q <= ST_HOLD; // [R10] [R14] [R16]
						peak_q <= cmax;
						held_q <= 1'b1;
						mem_go_q <= single;
					end
				end
				ST_HOLD: begin
					if (single && mem_done) begin
						if (last_q > level_q) begin
							peak_q <= last_q; // [R13]
							mem_go_q <= 1'b1;
						end else begin
							st_q <= ST_LIVE; // [R11]
							held_q <= 1'b0;
						end
					end else if (fv && filt > peak_q) begin
						peak_q <= filt; // [R12] [R15]
						mem_go_q <= single;
					end else if (!single && fv && !f_above) begin
						st_q <= ST_REARM; // [R16]
					end
				end
				default: begin
					if (fv && f_above) begin
						st_q <= ST_QUAL; // [R16]
						cand_q <= filt;
						dly_go_q <= 1'b1;
					end
				end
				endcase
			end
		end
	end

	// ------------------------------------------------------------
	// display outputs
	// ------------------------------------------------------------
	always @(posedge aclk) begin
		if (!aresetn) begin
			disp_value <= {W{1'b0}};
			disp_valid <= 1'b0;
			disp_all_on <= 1'b0;
			disp_held <= 1'b0;
		end else begin
			disp_valid <= fv;
			disp_all_on <= din_test; // [R17]
			disp_held <= held_q && (mode_q != `PVH_MODE_NORMAL);
			disp_value <= (held_q && mode_q != `PVH_MODE_NORMAL) ? peak_q : last_q; // [R20]
		end
	end

	// ------------------------------------------------------------
	// register reads
	// ------------------------------------------------------------
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `PVH_RESP_OKAY;
		end else begin
			s_axi_arready <= !s_axi_rvalid && !ar_take;
			if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
			if (ar_take) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= `PVH_RESP_OKAY;
				s_axi_rdata <= 32'h00000000;
				if (s_axi_araddr == `PVH_REG_CTRL) begin
					s_axi_rdata[1:0] <= mode_q;
				end else if (s_axi_araddr == `PVH_REG_LEVEL) begin
					s_axi_rdata <= {{16{level_q[15]}}, level_q};
				end else if (s_axi_araddr == `PVH_REG_QDELAY) begin
					s_axi_rdata[6:0] <= qdelay_q;
				end else if (s_axi_araddr == `PVH_REG_MWIN) begin
					s_axi_rdata[6:0] <= mwin_q;
				end else if (s_axi_araddr == `PVH_REG_FCYC) begin
					s_axi_rdata[6:0] <= fcyc_q;
				end else if (s_axi_araddr == `PVH_REG_STATUS) begin
					s_axi_rdata[5:0] <= {din_test, held_q, st_q, mode_q};
				end else if (s_axi_araddr == `PVH_REG_DISP) begin
					s_axi_rdata <= {{(32-W){disp_value[W-1]}}, disp_value};
				end else if (s_axi_araddr == `PVH_REG_FILT) begin
					s_axi_rdata <= {{(32-W){last_q[W-1]}}, last_q};
				end else begin
					s_axi_rresp <= `PVH_RESP_SLVERR;
				end
			end
		end
	end

endmodule // pvh_peak_hold

// file: tb/pvh_peak_hold_sva.sv
// assertion checker for the peak value hold block
`timescale 1ns/1ps
module pvh_peak_hold_sva #(
	parameter W = 16,
	parameter SEC_CYCLES = 20
) (
	input wire aclk,
	input wire aresetn,
	input wire reading_valid,
	input wire din_reset,
	input wire din_test,
	input wire disp_valid,
	input wire disp_all_on,
	input wire disp_held,
	input wire s_axi_awvalid,
	input wire s_axi_awready,
	input wire s_axi_wvalid,
	input wire s_axi_wready,
	input wire [1:0] s_axi_bresp,
	input wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire [31:0] s_axi_rdata,
	input wire s_axi_rvalid,
	input wire s_axi_rready
);
	// ----
	// bus and display properties
	// ----
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence s_wr_take;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_rd_take;
		s_axi_arvalid && s_axi_arready;
	endsequence
	sequence s_clr_held;
		din_reset ##1 din_reset;
	endsequence
	chk_test_lit: assert property (din_test |=> disp_all_on)
		else $error("display test not lit");
	chk_test_dark: assert property (!din_test |=> !disp_all_on)
		else $error("display test stuck on");
	chk_disp_latency: assert property (disp_valid |-> $past(reading_valid, 2) || $past(reading_valid, 28))
		else $error("display update without reading");
	chk_disp_pulse: assert property (disp_valid |=> !disp_valid)
		else $error("display strobe too long");
	chk_peak_clear: assert property (s_clr_held |=> !disp_held)
		else $error("peak held during clear");
	chk_wr_resp: assert property (s_wr_take |-> ##[1:2] s_axi_bvalid)
		else $error("write response missing");
	chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	chk_rd_resp: assert property (s_rd_take |=> s_axi_rvalid)
		else $error("read data late");
	chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
endmodule // pvh_peak_hold_sva

bind pvh_peak_hold pvh_peak_hold_sva #(.W(W), .SEC_CYCLES(SEC_CYCLES)) u_sva (.aclk, .aresetn, .reading_valid,
	.din_reset, .din_test, .disp_valid, .disp_all_on, .disp_held, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
	.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
	.s_axi_rvalid, .s_axi_rready);

// file: tb/pvh_src_model.sv
// converter model feeding one reading per call
`timescale 1ns/1ps
module pvh_src_model (
	input wire aclk,
	output reg reading_valid,
	output reg signed [15:0] reading
);
	initial begin
		reading_valid = 1'b0;
		reading = 16'h0000;
	end
	// data line not held once the strobe is gone
	task send(input logic signed [15:0] v);
		@(posedge aclk);
		reading_valid <= 1'b1;
		reading <= v;
		@(posedge aclk);
		reading_valid <= 1'b0;
		reading <= ~v;
	endtask
endmodule // pvh_src_model

// file: tb/testbench.sv
// self-checking bench for the peak value hold block
`timescale 1ns/1ps
`include "pvh_consts.vh"
module testbench;
	// ----
	// signals and tasks
	// ----
	logic aclk, aresetn, din_reset, din_test, awvalid, wvalid, bready, arvalid, rready;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata;
	wire reading_valid, disp_valid, disp_all_on, disp_held, awready, wready, bvalid, arready, rvalid;
	wire signed [15:0] reading, disp_value;
	wire [1:0] bresp, rresp;
	wire [31:0] rdata;
	int err_count, checks_done;
	pvh_src_model src (.aclk(aclk), .reading_valid(reading_valid), .reading(reading));
	pvh_peak_hold #(.W(16), .SEC_CYCLES(20)) dut (.aclk(aclk), .aresetn(aresetn),
		.reading_valid(reading_valid), .reading(reading), .din_reset(din_reset), .din_test(din_test),
		.disp_value(disp_value), .disp_valid(disp_valid), .disp_all_on(disp_all_on), .disp_held(disp_held),
		.s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
	initial begin
		aclk = 1'b0;
		forever #12.5 aclk = ~aclk;
	end
	task final_report;
		if (err_count == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		int n;
		logic aw, w;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		aw = 1'b0;
		w = 1'b0;
		n = 0;
		while (!(aw && w) && n < 50) begin
			@(posedge aclk);
			if (awready === 1'b1) begin
				aw = 1'b1;
				awvalid <= 1'b0;
			end
			if (wready === 1'b1) begin
				w = 1'b1;
				wvalid <= 1'b0;
			end
			n++;
		end
		@(posedge aclk);
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
		end while (bvalid !== 1'b1 && n < 100);
		bready <= 1'b0;
		if (bvalid !== 1'b1) begin
			err_count++;
			$display("unexpected at %0t: write response timeout", $time);
		end
		chk(bresp, er);
	endtask
	task rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		int n;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		n = 0;
		do begin
			@(posedge aclk);
			n++;
		end while (arready !== 1'b1 && n < 50);
		arvalid <= 1'b0;
		@(posedge aclk);
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
		end while (rvalid !== 1'b1 && n < 100);
		if (rvalid !== 1'b1) begin
			err_count++;
			$display("unexpected at %0t: read data timeout", $time);
		end
		rready <= 1'b0;
		chk(rdata, ed);
		chk(rresp, er);
	endtask
	task put(input logic signed [15:0] v);
		int n;
		src.send(v);
		n = 0;
		do begin
			@(posedge aclk);
			n++;
		end while (disp_valid !== 1'b1 && n < 40);
		if (disp_valid !== 1'b1) begin
			err_count++;
			$display("unexpected at %0t: display update timeout", $time);
		end
		repeat (2) @(posedge aclk);
	endtask
	task clr;
		din_reset <= 1'b1;
		repeat (3) @(posedge aclk);
		din_reset <= 1'b0;
		@(posedge aclk);
	endtask
	initial begin
		#(25 * 20000);
		err_count++;
		$display("unexpected at %0t: watchdog expired", $time);
		final_report();
	end
	// ----
	// test sequence
	// ----
	initial begin
		{aresetn, din_reset, din_test, awvalid, wvalid, bready, arvalid, rready} = 8'h00;
		{awaddr, araddr, wdata} = 48'h0;
		err_count = 0;
		checks_done = 0;
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		rd(`PVH_REG_CTRL, 32'h0, 2'h0);
		rd(`PVH_REG_LEVEL, 32'h64, 2'h0);
		rd(`PVH_REG_QDELAY, 32'h5, 2'h0);
		rd(`PVH_REG_MWIN, 32'h5, 2'h0);
		rd(`PVH_REG_FCYC, 32'h0, 2'h0);
		rd(8'h20, 32'h0, 2'h2);
		wr(8'h20, 32'h1, 2'h2);
		wr(`PVH_REG_LEVEL, 32'hFFFFF830, 2'h0);
		rd(`PVH_REG_LEVEL, 32'hFFFFFC19, 2'h0);
		wr(`PVH_REG_LEVEL, 32'h4E20, 2'h0);
		rd(`PVH_REG_LEVEL, 32'h270F, 2'h0);
		wr(`PVH_REG_QDELAY, 32'h78, 2'h0);
		rd(`PVH_REG_QDELAY, 32'h63, 2'h0);
		wr(`PVH_REG_LEVEL, 32'h64, 2'h0);
		wr(`PVH_REG_QDELAY, 32'h0, 2'h0);
		wr(`PVH_REG_MWIN, 32'h1, 2'h0);
		put(50);
		put(300);
		put(40);
		chk(disp_value, 32'h28);
		wr(`PVH_REG_CTRL, 32'h1, 2'h0);
		put(10);
		put(30);
		put(20);
		chk(disp_value, 32'h1E);
		chk(disp_held, 32'h1);
		clr();
		chk(disp_held, 32'h0);
		put(5);
		chk(disp_value, 32'h5);
		wr(`PVH_REG_CTRL, 32'h101, 2'h0);
		repeat (2) @(posedge aclk);
		chk(disp_held, 32'h0);
		wr(`PVH_REG_CTRL, 32'h2, 2'h0);
		put(50);
		chk(disp_held, 32'h0);
		chk(disp_value, 32'h32);
		put(150);
		repeat (6) @(posedge aclk);
		chk(disp_value, 32'h96);
		put(200);
		chk(disp_value, 32'hC8);
		put(80);
		chk(disp_value, 32'hC8);
		repeat (30) @(posedge aclk);
		chk(disp_held, 32'h0);
		chk(disp_value, 32'h50);
		put(150);
		repeat (36) @(posedge aclk);
		chk(disp_held, 32'h1);
		chk(disp_value, 32'h96);
		clr();
		wr(`PVH_REG_QDELAY, 32'h1, 2'h0);
		wr(`PVH_REG_CTRL, 32'h3, 2'h0);
		put(50);
		put(120);
		repeat (6) @(posedge aclk);
		chk(disp_held, 32'h0);
		repeat (30) @(posedge aclk);
		chk(disp_value, 32'h78);
		repeat (60) @(posedge aclk);
		chk(disp_held, 32'h1);
		put(180);
		chk(disp_value, 32'hB4);
		put(50);
		put(130);
		repeat (30) @(posedge aclk);
		chk(disp_value, 32'h82);
		rd(`PVH_REG_STATUS, 32'h1B, 2'h0);
		rd(`PVH_REG_DISP, 32'h82, 2'h0);
		din_test <= 1'b1;
		repeat (2) @(posedge aclk);
		chk(disp_all_on, 32'h1);
		din_test <= 1'b0;
		repeat (2) @(posedge aclk);
		chk(disp_all_on, 32'h0);
		wr(`PVH_REG_CTRL, 32'h0, 2'h0);
		wr(`PVH_REG_FCYC, 32'h5, 2'h0);
		put(1000);
		chk(disp_value, 32'h130);
		repeat (24) put(1000);
		chk({31'h0, disp_value >= 993}, 32'h1);
		final_report();
	end
endmodule // testbench
